// ### rtl/cc_array_pkg.sv
// Constants for the six-module capture/compare array
package cc_array_pkg;
    localparam int NUM_MODULES = 6;
    // Byte addresses
    localparam logic [7:0] CTRL_ADDR    = 8'h00;
    localparam logic [7:0] FLAGS_ADDR   = 8'h04;
    localparam logic [7:0] COUNT_ADDR   = 8'h08;
    localparam logic [7:0] PINS_ADDR    = 8'h0C;
    localparam logic [7:0] MOD_BASE     = 8'h10;
    localparam logic [7:0] MOD_END      = 8'h6F;
    // Word index within one module block of 16 bytes
    localparam logic [1:0] SLOT_MODE    = 2'h0;
    localparam logic [1:0] SLOT_LOW     = 2'h1;
    localparam logic [1:0] SLOT_HIGH    = 2'h2;
    // Control register bits
    localparam int CTRL_RUN = 0;
    localparam int CTRL_AIE = 1;
    localparam int CTRL_GIE = 2;
    // Mode register bits
    localparam int M_WIDE  = 7;
    localparam int M_COMPARE_ENABLE  = 6;
    localparam int M_RISE  = 5;
    localparam int M_FALL  = 4;
    localparam int M_MATCH = 3;
    localparam int M_TOG   = 2;
    localparam int M_PWM   = 1;
    localparam int M_IEN   = 0;
    // Reset values, then counter and low-byte top values
    localparam logic [7:0]  MODE_RST  = 8'h00;
    localparam logic [7:0]  CMP_RST   = 8'h00;
    localparam logic [15:0] COUNT_RST = 16'h0000;
    localparam logic [15:0] COUNT_TOP = 16'hFFFF;
    localparam logic [7:0]  LOW_TOP   = 8'hFF;
    // Bus responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ### rtl/cc_array.sv
// Six-module capture/compare array with shared counter, AXI4-Lite slave
//////////////////////////////////////////////////////////////////////////////
// Function
// [R1] Each module runs independently in one of six modes set by its mode bits
// [R2] Rise-only, fall-only or both-edge capture selected by the edge bits
// [R3] Capture copies the 16-bit counter into the module compare word
// [R4] Capture sets the sticky module flag; software clears it
// [R5] External pin must hold each level for two or more clocks
// [R6] Synchronised pin levels stay readable so software can see the edge
// [R7] Interrupt needs module enable, global enable and array enable
// [R8] Software timer sets the flag when counter equals compare word
// [R9] Low byte write clears compare enable, high byte write sets it
// [R10] Software writes the low byte before the high byte
// [R11] High-speed output inverts the pin on every 16-bit match; a match in the entry cycle sets the pin to one instead
// [R12] Entering high-speed output sets the toggle output to one
// [R13] Frequency output toggles on low-byte match and adds high into low
// [R14] High byte of zero gives a half-period of 256 counter clocks
// [R15] Compare enable and pwm with wide select clear is 8-bit PWM
// [R16] 8-bit PWM: high on low-byte match, low on low-byte overflow
// [R17] 8-bit PWM reloads low byte from high byte on low-byte overflow
// [R18] 8-bit PWM high fraction is (256 - high)/256; zero stays high
// [R19] 16-bit PWM: high on full match, low on counter overflow
// [R20] Software syncs 16-bit PWM updates to match interrupts
// [R21] Either PWM mode with compare enable clear holds the pin low
// [R22] Shared counter is 16 bits and wraps from all ones to zero
// [R23] Six modules, each with its own pin
// [R24] Unlisted mode codes do nothing on the pin; enabled match still flags
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/100ps
module cc_array (
    // Clock and reset
    input  wire logic        MCLK,
    input  wire logic        RST_B,
    // AXI4-Lite write address and data
    input  wire logic [7:0]  S_AXI_AWADDR,
    input  wire logic        S_AXI_AWVALID,
    output logic             S_AXI_AWREADY,
    input  wire logic [31:0] S_AXI_WDATA,
    input  wire logic [3:0]  S_AXI_WSTRB,
    input  wire logic        S_AXI_WVALID,
    output logic             S_AXI_WREADY,
    // AXI4-Lite write response
    output logic [1:0]       S_AXI_BRESP,
    output logic             S_AXI_BVALID,
    input  wire logic        S_AXI_BREADY,
    // AXI4-Lite read
    input  wire logic [7:0]  S_AXI_ARADDR,
    input  wire logic        S_AXI_ARVALID,
    output logic             S_AXI_ARREADY,
    output logic [31:0]      S_AXI_RDATA,
    output logic [1:0]       S_AXI_RRESP,
    output logic             S_AXI_RVALID,
    input  wire logic        S_AXI_RREADY,
    // Module pins, split into three signals
    input  wire logic [5:0]  MODULE_PIN_I,
    output logic [5:0]       MODULE_PIN_O,
    output logic [5:0]       MODULE_PIN_OE_B,
    // Interrupt request
    output logic             IRQ
);

    typedef struct packed {
        logic [5:0][7:0] mode;
        logic [5:0][7:0] cmp_lo;
        logic [5:0][7:0] cmp_hi;
        logic [5:0]      flag;
        logic [5:0]      pin;
        logic [5:0]      oe_b;
        logic [5:0]      hso_prev;
        logic [5:0]      sync1;
        logic [5:0]      sync2;
        logic [5:0]      sync3;
        logic [15:0]     cnt;
        logic            run;
        logic            aie;
        logic            gie;
        logic            irq;
        logic [7:0]      aw_addr;
        logic            aw_got;
        logic [31:0]     wdata;
        logic [3:0]      wstrb;
        logic            w_got;
        logic            awready;
        logic            wready;
        logic            bvalid;
        logic [1:0]      bresp;
        logic            arready;
        logic            rvalid;
        logic [31:0]     rdata;
        logic [1:0]      rresp;
    } state_type;

    state_type   s_r;
    state_type   s_nxt;
    logic [5:0]  cap_ev;
    logic [5:0]  hit;
    logic [5:0]  hso_now;
    logic [5:0]  pwm_now;
    logic        wr;
    logic [15:0] cnt_nxt;

    //////////////////////////////////////////////////////////////////////////
    always_comb begin
        logic        tick;
        logic        ovf16;
        logic        lovf;
        logic        in_mod;
        logic [2:0]  widx;
        logic [1:0]  wslot;
        logic [2:0]  ridx;
        logic [1:0]  rslot;
        logic [7:0]  ra;
        logic [7:0]  m;
        logic [7:0]  lo_eff;
        logic        capt;
        logic        cmpm;
        logic        frq;
        logic        pwm8;
        logic        eq8;
        logic        eq16;
        logic [5:0]  clr;
        logic [5:0]  set;
        s_nxt   = s_r;
        tick    = s_r.run;
        ovf16   = tick && (s_r.cnt == cc_array_pkg::COUNT_TOP);
        lovf    = tick && (s_r.cnt[7:0] == cc_array_pkg::LOW_TOP);
        cnt_nxt = tick ? s_r.cnt + 16'h0001 : s_r.cnt;   // see [R22]
        s_nxt.cnt = cnt_nxt;
        clr     = 6'h00;
        set     = 6'h00;
        cap_ev  = 6'h00;
        hit     = 6'h00;
        hso_now = 6'h00;
        pwm_now = 6'h00;
        // Pin synchronisers; third stage only feeds edge detection
        s_nxt.sync1 = MODULE_PIN_I;
        s_nxt.sync2 = s_r.sync1;
        s_nxt.sync3 = s_r.sync2;

        // Write channel capture, either order
        if (S_AXI_AWVALID && s_r.awready) begin
            s_nxt.aw_addr = S_AXI_AWADDR;
            s_nxt.aw_got  = 1'b1;
        end
        if (S_AXI_WVALID && s_r.wready) begin
            s_nxt.wdata = S_AXI_WDATA;
            s_nxt.wstrb = S_AXI_WSTRB;
            s_nxt.w_got = 1'b1;
        end
        wr     = s_r.aw_got && s_r.w_got && !s_r.bvalid;
        in_mod = (s_r.aw_addr >= cc_array_pkg::MOD_BASE)
              && (s_r.aw_addr <= cc_array_pkg::MOD_END);
        widx   = 3'(s_r.aw_addr[7:4] - 4'h1);
        wslot  = s_r.aw_addr[3:2];

        // Per-module behaviour; modules share only the counter
        for (int i = 0; i < cc_array_pkg::NUM_MODULES; i++) begin
            m    = s_r.mode[i];
            // see [R1] [R24]
            capt = !m[cc_array_pkg::M_MATCH] && !m[cc_array_pkg::M_TOG]
                && !m[cc_array_pkg::M_PWM];
            cmpm = m[cc_array_pkg::M_COMPARE_ENABLE] && !m[cc_array_pkg::M_RISE]
                && !m[cc_array_pkg::M_FALL];
            hso_now[i] = cmpm && m[cc_array_pkg::M_MATCH]
                && m[cc_array_pkg::M_TOG] && !m[cc_array_pkg::M_PWM];
            frq  = cmpm && m[cc_array_pkg::M_TOG] && m[cc_array_pkg::M_PWM];
            // PWM decode ignores compare enable so clearing it forces 0%
            pwm_now[i] = !m[cc_array_pkg::M_RISE] && !m[cc_array_pkg::M_FALL]
                && !m[cc_array_pkg::M_TOG] && m[cc_array_pkg::M_PWM];
            pwm8 = pwm_now[i] && !m[cc_array_pkg::M_WIDE];   // see [R15]
            // see [R2]
            cap_ev[i] = capt && (
                (m[cc_array_pkg::M_RISE] && s_r.sync2[i] && !s_r.sync3[i])
             || (m[cc_array_pkg::M_FALL] && !s_r.sync2[i] && s_r.sync3[i]));
            // Compare against the reloaded byte so a zero duty byte
            // re-asserts in the same cycle as the overflow
            lo_eff = (pwm8 && lovf) ? s_r.cmp_hi[i] : s_r.cmp_lo[i];
            eq8  = tick && (cnt_nxt[7:0] == lo_eff);
            eq16 = tick && (cnt_nxt == {s_r.cmp_hi[i], s_r.cmp_lo[i]});
            hit[i] = (frq || pwm8) ? eq8 : eq16;

            if (cap_ev[i]) begin
                s_nxt.cmp_lo[i] = s_r.cnt[7:0];   // see [R3]
                s_nxt.cmp_hi[i] = s_r.cnt[15:8];
                set[i] = 1'b1;                    // see [R4]
            end
            // see [R8] [R24]
            if (m[cc_array_pkg::M_MATCH] && m[cc_array_pkg::M_COMPARE_ENABLE] && hit[i])
                set[i] = 1'b1;

            if (hso_now[i] && !s_r.hso_prev[i]) begin
                s_nxt.pin[i] = 1'b1;              // see [R12]
            end else if (hso_now[i] && hit[i]) begin
                s_nxt.pin[i] = !s_r.pin[i];       // see [R11]
            end
            if (frq && hit[i]) begin
                s_nxt.pin[i] = !s_r.pin[i];       // see [R13]
                // Byte add wraps, so a zero step spans 256 clocks
                s_nxt.cmp_lo[i] = s_r.cmp_lo[i] + s_r.cmp_hi[i]; // see [R14]
            end
            if (pwm8 && lovf)
                s_nxt.cmp_lo[i] = s_r.cmp_hi[i];  // see [R17]
            if (pwm_now[i]) begin
                if (!m[cc_array_pkg::M_COMPARE_ENABLE])
                    s_nxt.pin[i] = 1'b0;          // see [R21]
                else if (hit[i])
                    s_nxt.pin[i] = 1'b1;          // see [R16] [R18] [R19]
                else if (pwm8 ? lovf : ovf16)
                    s_nxt.pin[i] = 1'b0;          // see [R16] [R19]
            end
            s_nxt.hso_prev[i] = hso_now[i];
            s_nxt.oe_b[i] = !(hso_now[i] || frq || pwm_now[i]);  // see [R23]

            // Software writes win over the module's own byte updates
            if (wr && in_mod && widx == 3'(i) && s_r.wstrb[0]) begin
                unique case (wslot)
                    cc_array_pkg::SLOT_MODE:
                        s_nxt.mode[i] = s_r.wdata[7:0];
                    cc_array_pkg::SLOT_LOW: begin
                        s_nxt.cmp_lo[i] = s_r.wdata[7:0];
                        s_nxt.mode[i][cc_array_pkg::M_COMPARE_ENABLE] = 1'b0; // see [R9]
                    end
                    cc_array_pkg::SLOT_HIGH: begin
                        s_nxt.cmp_hi[i] = s_r.wdata[7:0];
                        s_nxt.mode[i][cc_array_pkg::M_COMPARE_ENABLE] = 1'b1; // see [R9]
                    end
                    default: ;
                endcase
            end
        end

        // Global register writes and write response
        if (wr) begin
            s_nxt.bvalid = 1'b1;
            s_nxt.bresp  = cc_array_pkg::RESP_OKAY;
            s_nxt.aw_got = 1'b0;
            s_nxt.w_got  = 1'b0;
            if (in_mod) begin
                if (wslot == 2'h3)
                    s_nxt.bresp = cc_array_pkg::RESP_SLVERR;
            end else if (s_r.aw_addr == cc_array_pkg::CTRL_ADDR) begin
                if (s_r.wstrb[0]) begin
                    s_nxt.run = s_r.wdata[cc_array_pkg::CTRL_RUN];
                    s_nxt.aie = s_r.wdata[cc_array_pkg::CTRL_AIE];
                    s_nxt.gie = s_r.wdata[cc_array_pkg::CTRL_GIE];
                end
            end else if (s_r.aw_addr == cc_array_pkg::FLAGS_ADDR) begin
                if (s_r.wstrb[0])
                    clr = s_r.wdata[5:0];
            end else if (s_r.aw_addr == cc_array_pkg::COUNT_ADDR) begin
                if (s_r.wstrb[0])
                    s_nxt.cnt[7:0] = s_r.wdata[7:0];
                if (s_r.wstrb[1])
                    s_nxt.cnt[15:8] = s_r.wdata[15:8];
            end else if (s_r.aw_addr != cc_array_pkg::PINS_ADDR) begin
                s_nxt.bresp = cc_array_pkg::RESP_SLVERR;
            end
        end
        if (s_r.bvalid && S_AXI_BREADY)
            s_nxt.bvalid = 1'b0;
        // A hardware set in the clearing cycle is kept
        s_nxt.flag = (s_r.flag & ~clr) | set;             // see [R4]

        // Read channel
        ra    = S_AXI_ARADDR;
        ridx  = 3'(ra[7:4] - 4'h1);
        rslot = ra[3:2];
        if (S_AXI_ARVALID && s_r.arready) begin
            s_nxt.rvalid = 1'b1;
            s_nxt.rresp  = cc_array_pkg::RESP_OKAY;
            s_nxt.rdata  = 32'h0000_0000;
            if (ra >= cc_array_pkg::MOD_BASE && ra <= cc_array_pkg::MOD_END)
            begin
                unique case (rslot)
                    cc_array_pkg::SLOT_MODE:
                        s_nxt.rdata[7:0] = s_r.mode[ridx];
                    cc_array_pkg::SLOT_LOW:
                        s_nxt.rdata[7:0] = s_r.cmp_lo[ridx];
                    cc_array_pkg::SLOT_HIGH:
                        s_nxt.rdata[7:0] = s_r.cmp_hi[ridx];
                    default:
                        s_nxt.rresp = cc_array_pkg::RESP_SLVERR;
                endcase
            end else if (ra == cc_array_pkg::CTRL_ADDR) begin
                s_nxt.rdata[2:0] = {s_r.gie, s_r.aie, s_r.run};
            end else if (ra == cc_array_pkg::FLAGS_ADDR) begin
                s_nxt.rdata[5:0] = s_r.flag;
            end else if (ra == cc_array_pkg::COUNT_ADDR) begin
                s_nxt.rdata[15:0] = s_r.cnt;
            end else if (ra == cc_array_pkg::PINS_ADDR) begin
                s_nxt.rdata[5:0] = s_r.sync2;               // see [R6] [R5]
            end else begin
                s_nxt.rresp = cc_array_pkg::RESP_SLVERR;
            end
        end else if (s_r.rvalid && S_AXI_RREADY) begin
            s_nxt.rvalid = 1'b0;
        end

        // Ready flags registered from next state: one transfer at a time
        s_nxt.awready = !s_nxt.aw_got && !s_nxt.bvalid;
        s_nxt.wready  = !s_nxt.w_got && !s_nxt.bvalid;
        s_nxt.arready = !s_nxt.rvalid;
        s_nxt.irq = |(s_nxt.flag & {s_nxt.mode[5][0], s_nxt.mode[4][0],
            s_nxt.mode[3][0], s_nxt.mode[2][0], s_nxt.mode[1][0],
            s_nxt.mode[0][0]}) && s_nxt.gie && s_nxt.aie;  // see [R7]
    end

    //////////////////////////////////////////////////////////////////////////
    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            s_r         <= '0;
            s_r.mode    <= {6{cc_array_pkg::MODE_RST}};
            s_r.cmp_lo  <= {6{cc_array_pkg::CMP_RST}};
            s_r.cmp_hi  <= {6{cc_array_pkg::CMP_RST}};
            s_r.cnt     <= cc_array_pkg::COUNT_RST;
            s_r.oe_b    <= 6'h3F;
            s_r.awready <= 1'b1;
            s_r.wready  <= 1'b1;
            s_r.arready <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign S_AXI_AWREADY   = s_r.awready;
    assign S_AXI_WREADY    = s_r.wready;
    assign S_AXI_BVALID    = s_r.bvalid;
    assign S_AXI_BRESP     = s_r.bresp;
    assign S_AXI_ARREADY   = s_r.arready;
    assign S_AXI_RVALID    = s_r.rvalid;
    assign S_AXI_RDATA     = s_r.rdata;
    assign S_AXI_RRESP     = s_r.rresp;
    assign MODULE_PIN_O    = s_r.pin;
    assign MODULE_PIN_OE_B = s_r.oe_b;
    assign IRQ             = s_r.irq;

    //////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RST_B);

    logic wr_lo0;
    logic wr_hi0;
    assign wr_lo0 = wr && s_r.aw_addr == 8'h14 && s_r.wstrb[0];
    assign wr_hi0 = wr && s_r.aw_addr == 8'h18 && s_r.wstrb[0];

    cap_copy_a: assert property (cap_ev[0] && !wr |=>   // see [R3]
        {s_r.cmp_hi[0], s_r.cmp_lo[0]} == $past(s_r.cnt))
        else $error("capture did not copy counter");
    cap_flag_a: assert property (cap_ev[1] |=> s_r.flag[1])  // see [R4]
        else $error("capture did not set flag");
    irq_gate_a: assert property (IRQ == (|(s_r.flag & {s_r.mode[5][0],
        s_r.mode[4][0], s_r.mode[3][0], s_r.mode[2][0], s_r.mode[1][0],
        s_r.mode[0][0]}) && s_r.gie && s_r.aie))  // see [R7]
        else $error("interrupt gating wrong");
    low_clears_a: assert property (wr_lo0 |=> !s_r.mode[0][6])  // see [R9]
        else $error("low byte write kept compare enable");
    high_sets_a: assert property (wr_hi0 |=> s_r.mode[0][6])  // see [R9]
        else $error("high byte write left compare enable clear");
    hso_init_a: assert property (hso_now[2] && !s_r.hso_prev[2]
        |=> MODULE_PIN_O[2])  // see [R12]
        else $error("high-speed output not initialised high");
    hso_tog_a: assert property (hso_now[2] && s_r.hso_prev[2] && hit[2]
        |=> MODULE_PIN_O[2] != $past(MODULE_PIN_O[2]))  // see [R11]
        else $error("high-speed output missed toggle");
    pwm_off_a: assert property (pwm_now[4] && !s_r.mode[4][6]
        |=> !MODULE_PIN_O[4])  // see [R21]
        else $error("pwm not held low");
    timer_flag_a: assert property (s_r.mode[1] == 8'h48 && hit[1]
        |=> s_r.flag[1])  // see [R8]
        else $error("timer match did not set flag");
    bresp_a: assert property (s_r.aw_got && s_r.w_got && !s_r.bvalid
        |=> S_AXI_BVALID)
        else $error("write response late");

    cap_seen_c: cover property (cap_ev[0] ##1 s_r.flag[0]);
    pwm_high_c: cover property (pwm_now[4] && hit[4] ##1 MODULE_PIN_O[4]);
    read_done_c: cover property (S_AXI_RVALID && S_AXI_RREADY);
endmodule

// ### tb/pin_source.sv
// Far-side source model for the six module pins
`timescale 1ns/100ps
module pin_source (
    // Clock and reset
    input  wire logic       mclk,
    input  wire logic       rst_b,
    // Requested levels and design drive
    input  wire logic [5:0] want,
    input  wire logic [5:0] pin_o,
    input  wire logic [5:0] pin_oe_b,
    // Resolved pin levels
    output logic      [5:0] pin_lvl
);
    logic [5:0] drv_r;
    logic       hold_r;

    // A new level waits out one extra clock, so each stands two at least
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            drv_r  <= 6'h00;
            hold_r <= 1'h0;
        end else if (!hold_r && want != drv_r) begin
            drv_r  <= want;
            hold_r <= 1'h1;
        end else begin
            hold_r <= 1'h0;
        end
    end

    // Design drive wins wherever its enable is low
    assign pin_lvl = (pin_oe_b & drv_r) | (~pin_oe_b & pin_o);
endmodule

// ### tb/cc_array_tb.sv
// Self-checking bench for the capture/compare array
`timescale 1ns/100ps
module cc_array_tb;
    logic        mclk, rst_b, awvalid, wvalid, bready, arvalid, rready;
    logic        awready, wready, bvalid, arready, rvalid, irq;
    logic [7:0]  awaddr, araddr, lo;
    logic [31:0] wdata, rdata, rd;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp;
    logic [5:0]  want, pin_lvl, pin_o, pin_oe_b;
    logic [15:0] v1, v2;
    logic [7:0]  capm [3];
    logic [7:0]  hv [3];
    integer      seed, fails, comparisons, c;

    cc_array cc_array_inst (
        .MCLK(mclk), .RST_B(rst_b),
        .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
        .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
        .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
        .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
        .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
        .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
        .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
        .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
        .S_AXI_RREADY(rready), .MODULE_PIN_I(pin_lvl),
        .MODULE_PIN_O(pin_o), .MODULE_PIN_OE_B(pin_oe_b), .IRQ(irq));

    pin_source pin_source_inst (.mclk(mclk), .rst_b(rst_b), .want(want),
        .pin_o(pin_o), .pin_oe_b(pin_oe_b), .pin_lvl(pin_lvl));

    initial begin
        mclk = 1'h0;
        forever #20 mclk = ~mclk;
    end

    //////////////////////////////////////////////////////////////////////
    task automatic wrap_up;
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic tmo;
        fails++;
        $display("[FAIL] wait expected done seen timeout");
        wrap_up();
    endtask

    task automatic chk(input string what, input logic [31:0] e,
                       input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", what, e, g);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] er = cc_array_pkg::RESP_OKAY);
        int   n;
        logic got;
        @(posedge mclk);
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'h1;
        wvalid  <= 1'h1;
        bready  <= 1'h1;
        got = 1'h0;
        n = 0;
        while (!got && n < 200) begin
            @(posedge mclk);
            n++;
            if (awready) awvalid <= 1'h0;
            if (wready) wvalid <= 1'h0;
            if (bvalid) begin
                bready <= 1'h0;
                got = 1'h1;
                chk("write resp", {30'h0, er}, {30'h0, bresp});
            end
        end
        if (!got) tmo();
    endtask

    task automatic rdr(input logic [7:0] a,
                       input logic [1:0] er = cc_array_pkg::RESP_OKAY);
        int   n;
        logic got;
        @(posedge mclk);
        araddr  <= a;
        arvalid <= 1'h1;
        rready  <= 1'h1;
        got = 1'h0;
        n = 0;
        while (!got && n < 200) begin
            @(posedge mclk);
            n++;
            if (arready) arvalid <= 1'h0;
            if (rvalid) begin
                rready <= 1'h0;
                rd = rdata;
                got = 1'h1;
                chk("read resp", {30'h0, er}, {30'h0, rresp});
            end
        end
        if (!got) tmo();
    endtask

    // Cycles between two successive changes of one module's pin
    task automatic halfp(input int i, output int n);
        logic s;
        int   t;
        s = pin_o[i];
        t = 0;
        while (pin_o[i] === s && t < 600) begin
            @(posedge mclk);
            t++;
        end
        s = pin_o[i];
        n = 0;
        while (pin_o[i] === s && n < 600) begin
            @(posedge mclk);
            n++;
        end
        if (t >= 600 || n >= 600) tmo();
    endtask

    // A 512-cycle window spans two whole 8-bit periods at any phase
    task automatic hicount(input int i, output int n);
        n = 0;
        repeat (512) begin
            @(posedge mclk);
            if (pin_o[i] === 1'h1) n++;
        end
    endtask

    function automatic logic [7:0] ma(input int m, input logic [1:0] s);
        return cc_array_pkg::MOD_BASE + 8'(m * 16) + {4'h0, s, 2'h0};
    endfunction

    function automatic logic [15:0] cap_exp(input logic [7:0] md,
        input logic [15:0] a, input logic [15:0] b);
        return md[cc_array_pkg::M_FALL] ? b : a;
    endfunction

    function automatic int half_exp(input logic [7:0] h);
        return (h == 8'h00) ? 256 : int'(h);
    endfunction

    //////////////////////////////////////////////////////////////////////
    initial begin
        seed = 35;
        fails = 0;
        comparisons = 0;
        rst_b = 1'h0;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        awaddr = 8'h00;
        araddr = 8'h00;
        wdata = 32'h0;
        wstrb = 4'h3;
        want = 6'h00;
        capm = '{8'h20, 8'h10, 8'h30};
        repeat (8) @(posedge mclk);
        rst_b <= 1'h1;
        chk("pin enables", 32'h3F, {26'h0, pin_oe_b});
        rdr(cc_array_pkg::CTRL_ADDR);
        chk("control reset", 32'h0, rd);
        rdr(ma(0, 2'h3), cc_array_pkg::RESP_SLVERR);
        chk("unmapped read", 32'h0, rd);
        wr(8'h70, 32'h1, cc_array_pkg::RESP_SLVERR);
        // Counter stopped, so each capture has one exact expected value
        for (int m = 0; m < 3; m++) begin
            v1 = 16'($random(seed));
            v2 = 16'($random(seed));
            wr(ma(m, 2'h0), {24'h0, capm[m]});
            wr(cc_array_pkg::COUNT_ADDR, {16'h0, v1});
            want <= 6'h01 << m;
            repeat (8) @(posedge mclk);
            rdr(cc_array_pkg::PINS_ADDR);
            chk("pin level", 32'h1 << m, rd);
            wr(cc_array_pkg::COUNT_ADDR, {16'h0, v2});
            want <= 6'h00;
            repeat (8) @(posedge mclk);
            rdr(ma(m, 2'h1));
            lo = rd[7:0];
            rdr(ma(m, 2'h2));
            chk("capture", {16'h0, cap_exp(capm[m], v1, v2)},
                {16'h0, rd[7:0], lo});
            rdr(cc_array_pkg::FLAGS_ADDR);
            chk("flag", 32'h1, {31'h0, rd[m]});
        end
        for (int k = 0; k < 8; k++) begin
            wr(ma(0, 2'h0), {24'h0, 7'h18, k[0]});
            wr(cc_array_pkg::CTRL_ADDR, {29'h0, k[2], k[1], 1'h0});
            repeat (2) @(posedge mclk);
            chk("irq", {31'h0, k[2] & k[1] & k[0]}, {31'h0, irq});
        end
        wr(cc_array_pkg::FLAGS_ADDR, 32'h3F);
        rdr(cc_array_pkg::FLAGS_ADDR);
        chk("flags cleared", 32'h0, {26'h0, rd[5:0]});
        // Unlisted code: no drive, no capture on a pin edge
        wr(ma(5, 2'h0), 32'h24);
        want <= 6'h20;
        repeat (8) @(posedge mclk);
        rdr(cc_array_pkg::FLAGS_ADDR);
        chk("unlisted flag", 32'h0, {31'h0, rd[5]});
        chk("unlisted drive", 32'h1, {31'h0, pin_oe_b[5]});
        // Software timer
        lo = 8'($random(seed));
        wr(ma(1, 2'h0), 32'h48);
        wr(ma(1, 2'h1), {24'h0, lo});
        rdr(ma(1, 2'h0));
        chk("mode low write", 32'h08, rd);
        wr(ma(1, 2'h2), 32'h12);
        rdr(ma(1, 2'h0));
        chk("mode high write", 32'h48, rd);
        wr(cc_array_pkg::COUNT_ADDR, {16'h0, 8'h12, lo} - 32'h28);
        wr(cc_array_pkg::CTRL_ADDR, 32'h1);
        rdr(cc_array_pkg::FLAGS_ADDR);
        chk("timer early", 32'h0, {31'h0, rd[1]});
        repeat (50) @(posedge mclk);
        rdr(cc_array_pkg::FLAGS_ADDR);
        chk("timer match", 32'h1, {31'h0, rd[1]});
        // High-speed output on module 2, match at 0x0100
        wr(ma(2, 2'h1), 32'h00);
        wr(ma(2, 2'h2), 32'h01);
        wr(cc_array_pkg::COUNT_ADDR, 32'h0200);
        wr(ma(2, 2'h0), 32'h4C);
        // Pin and enable follow the mode register by one clock
        @(negedge mclk);
        chk("hso on", 32'h2, {30'h0, pin_o[2], pin_oe_b[2]});
        for (int t = 0; t < 2; t++) begin
            wr(cc_array_pkg::COUNT_ADDR, 32'h00E2);
            repeat (40) @(posedge mclk);
            chk("hso toggle", {31'h0, t[0]}, {31'h0, pin_o[2]});
        end
        // Frequency output on module 3
        hv = '{8'h00, 8'h01, 8'($random(seed))};
        wr(ma(3, 2'h0), 32'h46);
        for (int h = 0; h < 3; h++) begin
            wr(ma(3, 2'h2), {24'h0, hv[h]});
            halfp(3, c);
            chk("half period", half_exp(hv[h]), c);
        end
        // 8-bit PWM on module 4
        hv = '{8'h00, 8'hFF, 8'($random(seed))};
        wr(ma(4, 2'h0), 32'h42);
        for (int h = 0; h < 3; h++) begin
            wr(ma(4, 2'h2), {24'h0, hv[h]});
            repeat (300) @(posedge mclk);
            hicount(4, c);
            chk("pwm8 high", 512 - 2 * hv[h], c);
        end
        wr(ma(4, 2'h1), 32'h00);
        hicount(4, c);
        chk("pwm8 off", 32'h0, c);
        // 16-bit PWM on module 4, match at 0xFFF8
        // Mode first: an 8-bit reload between the byte writes would eat F8
        wr(ma(4, 2'h0), 32'hCB);
        wr(ma(4, 2'h1), 32'hF8);
        wr(ma(4, 2'h2), 32'hFF);
        wr(cc_array_pkg::COUNT_ADDR, 32'hFFE0);
        repeat (26) @(posedge mclk);
        chk("wide_width_select high", 32'h1, {31'h0, pin_o[4]});
        repeat (10) @(posedge mclk);
        chk("wide_width_select low", 32'h0, {31'h0, pin_o[4]});
        rdr(cc_array_pkg::FLAGS_ADDR);
        chk("wide_width_select flag", 32'h1, {31'h0, rd[4]});
        wrap_up();
    end
endmodule
